// ### design/trig_fault_consts.svh
// Offsets, field positions, reset values and timing counts of the trigger and fault block.
// Assumes inclusion by bare name from design files only.
`ifndef TRIG_FAULT_CONSTS_SVH
`define TRIG_FAULT_CONSTS_SVH

// ==========================================
// Register offsets
`define OFS_TRIGGER_CONTROL 5'h0a
`define OFS_MISC_PIN_CONFIG 5'h0b
`define OFS_FAULT_ACTION_SELECT 5'h10
`define OFS_ADC_CONFIG 5'h08
`define OFS_FIRST_LIMITS 5'h12
`define OFS_SECOND_LIMITS 5'h13
`define OFS_TEMP_LIMITS 5'h14
`define OFS_SELFTEST_SUM 5'h15
`define OFS_STATUS 5'h17
`define OFS_SOFT_RESET 5'h07

// ==========================================
// Field positions
`define BIT_SELFTEST_GO 3
`define BIT_FUSE_RELOAD_GO 1
`define BIT_CONV_GO 0
`define BIT_FUSE_ON_SOFT_RST 2
`define BIT_ALARM_LEVEL_SEL 1
`define BIT_INPUT_PIN_EN 0
`define BIT_SINGLE_RUN 0
`define SOFT_RESET_KEY 8'had

// ==========================================
// Reset values
`define RST_TRIGGER_CONTROL 16'h0000
`define RST_MISC_PIN_CONFIG 16'h0000
`define RST_FAULT_ACTION_SELECT 16'h8020
`define RST_LIMITS 16'hff00
`define RST_ADC_CONFIG 16'h0000
`define RST_SELFTEST_SUM 16'h0000

// ==========================================
// Timing counts
`define FUSE_LOAD_CYCLES 8'd16
`define CONV_SEQ_CYCLES 8'd32

`endif

// ### design/trig_fault_pkg.sv
// Types shared by the trigger and fault block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package trig_fault_pkg;

	// ==========================================
	// Output action, ordered by severity
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_CLEAR = 2'h1,
		ACT_ALARM = 2'h2,
		ACT_HIZ = 2'h3
	} action_t;

	// ==========================================
	// Fault sources from the surrounding monitors
	typedef struct packed {
		logic selfCheck;
		logic link;
		logic reference;
		logic overheat;
		logic heatWarning;
	} fault_in_t;

	// One measured result with its strobe
	typedef struct packed {
		logic valid;
		logic [11:0] code;
	} result_t;

	// Output stage control
	typedef struct packed {
		logic forceClear;
		logic alarmOn;
		logic powerDown;
		logic alarmLevel;
	} out_ctl_t;

endpackage

// ### design/trigger_fault_regs.sv
// Trigger, pin configuration and fault action registers with their one-shot engines.
// Assumes a single clk domain register port; results and fault pulses are synchronous to clk.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "trig_fault_consts.svh"

// What this block does
// - Self-test go bit starts register CRC, compares to expected sum, self-clears
// - Fuse reload go bit copies fuse array to latches, then self-clears
// - Continuous mode: conversion bit is a level run enable
// - Single-run mode: bit starts one sequence, cleared when sequence completes
// - Clearing conversion bit during single run aborts the sequence
// - Soft reset reloads fuses only when reload-on-soft-reset bit is set
// - Effective level drives output in alarm-voltage action; hardware reset shows the select-bit reset value (low)
// - Pin enable low: pin is polarity, channel samples ground; high: live channel
// - Action codes: none, clear state, alarm voltage, high-impedance power-down
// - Self-check action in bits 15-14, resets to alarm voltage
// - Die temperature action bits 13-12 applies outside temperature limits
// - Second input action bits 11-10 applies outside its limits
// - First input action bits 9-8 applies outside its limits
// - Link action bits 7-6 answers frame CRC error or watchdog timeout
// - Reference action bits 5-4 resets to alarm voltage
// - Overheat action bits 3-2 answers error above 130 C
// - Heat warning action bits 1-0 answers warning above 85 C
// - Single-run select zero is continuous (default), one is single-run
// - Limit fault after repeat count plus one consecutive out-of-limit results
// - High limit byte padded with four ones, compared greater-than to result
module trigger_fault_regs #(
	parameter int CRC_WORDS = 8,
	parameter int RUN_MAX = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdData,
	// Pins and monitors
	input wire logic polarityPin,
	input wire trig_fault_pkg::result_t firstInput,
	input wire trig_fault_pkg::result_t secondInput,
	input wire trig_fault_pkg::result_t dieTemp,
	input wire trig_fault_pkg::fault_in_t faults,
	input wire logic convSeqDone,
	// Fuse array
	input wire logic [15:0] fuseWord,
	output logic [3:0] fuseAddr,
	output logic fuseLatchWe,
	// Converter and output stage
	output logic convRun,
	output logic convAbort,
	output logic secondChanLive,
	output trig_fault_pkg::out_ctl_t outCtl,
	output logic selftestFail
);

	initial begin
		if (CRC_WORDS < 1 || CRC_WORDS > 16 || RUN_MAX != 8) begin
			$error("trigger_fault_regs: unsupported parameters");
		end
	end

	// ==========================================
	// Synchronised polarity pin
	logic polMeta_r, polSync_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			polMeta_r <= 1'b0;
			polSync_r <= 1'b0;
		end else begin
			polMeta_r <= polarityPin;
			polSync_r <= polMeta_r;
		end
	end

	// ==========================================
	// Registers
	logic [15:0] actSel_r, limFirst_r, limSecond_r, limTemp_r, expSum_r;
	logic fuseOnSoft_r, alarmSel_r, pinEn_r, singleRun_r;
	logic [2:0] repeatCnt_r;
	logic convGo_r, fuseGo_r, testGo_r, testFail_r;
	logic wrHit, softRst;
	logic [15:0] rdNxt;
	assign wrHit = regWrite;
	assign softRst = regWrite && regAddr == `OFS_SOFT_RESET && regWrData[7:0] == `SOFT_RESET_KEY;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			actSel_r <= `RST_FAULT_ACTION_SELECT;
			fuseOnSoft_r <= 1'b0;
			alarmSel_r <= 1'b0;
			pinEn_r <= 1'b0;
			singleRun_r <= 1'b0;
			repeatCnt_r <= 3'h0;
			limFirst_r <= `RST_LIMITS;
			limSecond_r <= `RST_LIMITS;
			limTemp_r <= `RST_LIMITS;
			expSum_r <= `RST_SELFTEST_SUM;
		end else if (wrHit) begin
			if (regAddr == `OFS_FAULT_ACTION_SELECT) begin
				actSel_r <= regWrData;
			end else if (regAddr == `OFS_MISC_PIN_CONFIG) begin
				fuseOnSoft_r <= regWrData[`BIT_FUSE_ON_SOFT_RST];
				alarmSel_r <= regWrData[`BIT_ALARM_LEVEL_SEL];
				pinEn_r <= regWrData[`BIT_INPUT_PIN_EN];
			end else if (regAddr == `OFS_ADC_CONFIG) begin
				singleRun_r <= regWrData[`BIT_SINGLE_RUN];
				repeatCnt_r <= regWrData[7:5];
			end else if (regAddr == `OFS_FIRST_LIMITS) begin
				limFirst_r <= regWrData;
			end else if (regAddr == `OFS_SECOND_LIMITS) begin
				limSecond_r <= regWrData;
			end else if (regAddr == `OFS_TEMP_LIMITS) begin
				limTemp_r <= regWrData;
			end else if (regAddr == `OFS_SELFTEST_SUM) begin
				expSum_r <= regWrData;
			end
		end
	end

	// ==========================================
	// Conversion trigger
	logic trigWr;
	assign trigWr = regWrite && regAddr == `OFS_TRIGGER_CONTROL;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			convGo_r <= 1'b0;
			convAbort <= 1'b0;
		end else begin
			convAbort <= 1'b0;
			if (trigWr) begin
				convGo_r <= regWrData[`BIT_CONV_GO];
				if (!regWrData[`BIT_CONV_GO] && convGo_r && singleRun_r) begin
					convAbort <= 1'b1;
				end
			end else if (singleRun_r && convSeqDone && convGo_r) begin
				convGo_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			convRun <= 1'b0;
		end else begin
			convRun <= trigWr ? regWrData[`BIT_CONV_GO] : (convGo_r && !(singleRun_r && convSeqDone));
		end
	end

	// ==========================================
	// Fuse reload engine
	logic [3:0] fuseIdx_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fuseGo_r <= 1'b0;
			fuseIdx_r <= 4'h0;
			fuseLatchWe <= 1'b0;
		end else if (fuseGo_r) begin
			fuseLatchWe <= 1'b1;
			fuseIdx_r <= fuseIdx_r + 4'h1;
			if (fuseIdx_r == 4'hf) begin
				fuseGo_r <= 1'b0;
			end
		end else begin
			fuseLatchWe <= 1'b0;
			fuseIdx_r <= 4'h0;
			// Software retries here after a fuse CRC error
			if (trigWr && regWrData[`BIT_FUSE_RELOAD_GO]) begin
				fuseGo_r <= 1'b1;
			end else if (softRst && fuseOnSoft_r) begin
				fuseGo_r <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fuseAddr <= 4'h0;
		end else begin
			fuseAddr <= fuseIdx_r;
		end
	end

	// ==========================================
	// Register self-test: CRC-16 over configuration words
	function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 15; i >= 0; i--) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h1021 : 16'h0000);
		end
		return r;
	endfunction

	logic [15:0] cfgWord;
	logic [15:0] crc_r;
	logic [3:0] testIdx_r;
	always_comb begin
		case (testIdx_r)
			4'h0: cfgWord = actSel_r;
			4'h1: cfgWord = {13'h0000, fuseOnSoft_r, alarmSel_r, pinEn_r};
			4'h2: cfgWord = {8'h00, repeatCnt_r, 4'h0, singleRun_r};
			4'h3: cfgWord = limFirst_r;
			4'h4: cfgWord = limSecond_r;
			4'h5: cfgWord = limTemp_r;
			default: cfgWord = 16'h0000;
		endcase
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			testGo_r <= 1'b0;
			testIdx_r <= 4'h0;
			crc_r <= 16'hffff;
			testFail_r <= 1'b0;
		end else if (testGo_r) begin
			crc_r <= crcStep(crc_r, cfgWord);
			testIdx_r <= testIdx_r + 4'h1;
			if (testIdx_r == 4'(CRC_WORDS - 1)) begin
				testGo_r <= 1'b0;
				testFail_r <= crcStep(crc_r, cfgWord) != expSum_r;
			end
		end else if (trigWr && regWrData[`BIT_SELFTEST_GO]) begin
			testGo_r <= 1'b1;
			testIdx_r <= 4'h0;
			crc_r <= 16'hffff;
		end
	end
	assign selftestFail = testFail_r;

	// ==========================================
	// Limit checks with consecutive-run counting
	function automatic logic outOfLimits(input logic [15:0] lim, input logic [11:0] code);
		return (code > {lim[15:8], 4'hf}) || (code < {lim[7:0], 4'h0});
	endfunction

	logic [2:0] runCnt_r [3];
	logic [2:0] limFault_r;
	logic [15:0] limSet [3];
	trig_fault_pkg::result_t resSet [3];
	assign limSet[0] = limFirst_r;
	assign limSet[1] = limSecond_r;
	assign limSet[2] = limTemp_r;
	assign resSet[0] = firstInput;
	assign resSet[1] = pinEn_r ? secondInput : '0;
	assign resSet[2] = dieTemp;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int k = 0; k < 3; k++) begin
				runCnt_r[k] <= 3'h0;
				limFault_r[k] <= 1'b0;
			end
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (resSet[k].valid) begin
					if (!outOfLimits(limSet[k], resSet[k].code)) begin
						runCnt_r[k] <= 3'h0;
						limFault_r[k] <= 1'b0;
					end else if (runCnt_r[k] >= repeatCnt_r) begin
						limFault_r[k] <= 1'b1;
					end else begin
						runCnt_r[k] <= runCnt_r[k] + 3'h1;
					end
				end
			end
		end
	end

	// ==========================================
	// Action resolution
	function automatic logic [1:0] gateAct(input logic on, input logic [1:0] a);
		return on ? a : 2'h0;
	endfunction

	logic [1:0] worst;
	logic levelEff;
	always_comb begin
		worst = 2'h0;
		worst = gateAct(faults.selfCheck || testFail_r, actSel_r[15:14]);
		worst = (gateAct(limFault_r[2], actSel_r[13:12]) > worst) ? actSel_r[13:12] : worst;
		worst = (gateAct(limFault_r[1], actSel_r[11:10]) > worst) ? actSel_r[11:10] : worst;
		worst = (gateAct(limFault_r[0], actSel_r[9:8]) > worst) ? actSel_r[9:8] : worst;
		worst = (gateAct(faults.link, actSel_r[7:6]) > worst) ? actSel_r[7:6] : worst;
		worst = (gateAct(faults.reference, actSel_r[5:4]) > worst) ? actSel_r[5:4] : worst;
		worst = (gateAct(faults.overheat, actSel_r[3:2]) > worst) ? actSel_r[3:2] : worst;
		worst = (gateAct(faults.heatWarning, actSel_r[1:0]) > worst) ? actSel_r[1:0] : worst;
	end
	assign levelEff = alarmSel_r | (polSync_r & ~pinEn_r);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			// Level shown during reset is the select-bit reset value
			outCtl <= '{forceClear: 1'b0, alarmOn: 1'b1, powerDown: 1'b0, alarmLevel: 1'b0};
			secondChanLive <= 1'b0;
		end else begin
			outCtl.forceClear <= worst == trig_fault_pkg::ACT_CLEAR;
			outCtl.alarmOn <= worst == trig_fault_pkg::ACT_ALARM;
			outCtl.powerDown <= worst == trig_fault_pkg::ACT_HIZ;
			outCtl.alarmLevel <= levelEff;
			secondChanLive <= pinEn_r;
		end
	end

	// ==========================================
	// Read port, one cycle latency
	always_comb begin
		rdNxt = 16'h0000;
		if (regAddr == `OFS_TRIGGER_CONTROL) begin
			rdNxt = {12'h000, testGo_r, 1'b0, fuseGo_r, convGo_r};
		end else if (regAddr == `OFS_MISC_PIN_CONFIG) begin
			rdNxt = {13'h0000, fuseOnSoft_r, alarmSel_r, pinEn_r};
		end else if (regAddr == `OFS_FAULT_ACTION_SELECT) begin
			rdNxt = actSel_r;
		end else if (regAddr == `OFS_ADC_CONFIG) begin
			rdNxt = {8'h00, repeatCnt_r, 4'h0, singleRun_r};
		end else if (regAddr == `OFS_FIRST_LIMITS) begin
			rdNxt = limFirst_r;
		end else if (regAddr == `OFS_SECOND_LIMITS) begin
			rdNxt = limSecond_r;
		end else if (regAddr == `OFS_TEMP_LIMITS) begin
			rdNxt = limTemp_r;
		end else if (regAddr == `OFS_SELFTEST_SUM) begin
			rdNxt = expSum_r;
		end else if (regAddr == `OFS_STATUS) begin
			rdNxt = {10'h000, levelEff, limFault_r, testFail_r, convRun};
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData <= 16'h0000;
		end else if (regRead) begin
			regRdData <= rdNxt;
		end
	end

endmodule

// ### tb/tb_top.sv
// Self-checking bench for the trigger and fault register block.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
module tb_top;
	logic clk, sys_rst, regWrite, regRead, polarityPin, convSeqDone;
	logic [4:0] regAddr;
	logic [15:0] regWrData, regRdData;
	trig_fault_pkg::result_t firstInput;
	trig_fault_pkg::fault_in_t faults;
	trig_fault_pkg::out_ctl_t outCtl;
	logic [3:0] fuseAddr;
	logic fuseLatchWe, convRun, convAbort, secondChanLive, selftestFail;
	int n_mismatch, checks_done, cyc, n;
	trigger_fault_regs trigger_fault_regs_i (.clk, .sys_rst, .regAddr, .regWrData, .regWrite,
		.regRead, .regRdData, .polarityPin, .firstInput, .secondInput(13'h0000),
		.dieTemp(13'h0000), .faults, .convSeqDone, .fuseWord(16'h0000), .fuseAddr,
		.fuseLatchWe, .convRun, .convAbort, .secondChanLive, .outCtl, .selftestFail);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard, well above the whole sequence
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// ==========
	// Shared tasks
	task chk(input string s, input logic [15:0] e, input logic [15:0] v);
		checks_done++;
		if (v !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", s, e, v);
		end
	endtask
	task cy(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		chk("read", e, regRdData);
	endtask
	task cnt(input int k);
		n = 0;
		repeat (k) begin
			@(posedge clk);
			#1;
			if (fuseLatchWe === 1'b1) n++;
		end
	endtask
	task send(input logic [11:0] v);
		@(posedge clk);
		firstInput <= {1'b1, v};
		@(posedge clk);
		firstInput.valid <= 1'b0;
		cy(3);
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========
	// Scenarios
	task t_regs();
		rd(5'h0a, 16'h0000);
		rd(5'h10, 16'h8020);
		wr(5'h0b, 16'hffff);
		rd(5'h0b, 16'h0007);
		wr(5'h0b, 16'h0000);
		wr(5'h1f, 16'hffff);
		rd(5'h1f, 16'h0000);
	endtask
	task t_pol();
		polarityPin <= 1'b1;
		wr(5'h0b, 16'h0000);
		cy(4);
		chk("level", 1'b1, outCtl.alarmLevel);
		wr(5'h0b, 16'h0001);
		cy(4);
		chk("level", 1'b0, outCtl.alarmLevel);
		chk("live", 1'b1, secondChanLive);
		wr(5'h0b, 16'h0002);
		cy(4);
		chk("level", 1'b1, outCtl.alarmLevel);
		polarityPin <= 1'b0;
		wr(5'h0b, 16'h0000);
	endtask
	task t_act();
		int sh[5] = '{14, 6, 4, 2, 0};
		logic [3:0] ex[4] = '{4'h0, 4'h8, 4'h4, 4'h2};
		for (int i = 0; i < 5; i++) begin
			for (int c = 0; c < 4; c++) begin
				wr(5'h10, 16'(c) << sh[i]);
				faults <= 5'h10 >> i;
				cy(4);
				chk("outCtl", ex[c], outCtl);
				faults <= 5'h00;
			end
		end
		wr(5'h10, 16'hc080);
		faults <= 5'h18;
		cy(4);
		chk("worst", 4'h2, outCtl);
		wr(5'h10, 16'h4080);
		cy(4);
		chk("worst", 4'h4, outCtl);
		faults <= 5'h00;
	endtask
	task t_conv();
		wr(5'h0a, 16'h0001);
		#1;
		chk("run", 1'b1, convRun);
		rd(5'h0a, 16'h0001);
		wr(5'h0a, 16'h0000);
		#1;
		chk("run", 1'b0, convRun);
		wr(5'h08, 16'h0001);
		wr(5'h0a, 16'h0001);
		@(posedge clk);
		convSeqDone <= 1'b1;
		@(posedge clk);
		convSeqDone <= 1'b0;
		cy(1);
		chk("run", 1'b0, convRun);
		rd(5'h0a, 16'h0000);
		wr(5'h0a, 16'h0001);
		wr(5'h0a, 16'h0000);
		#1;
		chk("abort", 1'b1, convAbort);
		wr(5'h08, 16'h0000);
	endtask
	task t_lim();
		wr(5'h12, 16'h8000);
		wr(5'h08, 16'h0020);
		wr(5'h10, 16'h0300);
		send(12'h80f);
		send(12'h80f);
		chk("edge", 4'h0, outCtl);
		send(12'h810);
		chk("once", 4'h0, outCtl);
		send(12'h810);
		chk("twice", 4'h2, outCtl);
		wr(5'h08, 16'h0000);
		wr(5'h12, 16'hff00);
	endtask
	task t_fuse();
		wr(5'h0a, 16'h0002);
		cnt(20);
		chk("fuse", 16, n);
		wr(5'h0b, 16'h0004);
		wr(5'h07, 16'h00ad);
		cnt(24);
		chk("softfuse", 16, n);
		wr(5'h0b, 16'h0000);
		wr(5'h07, 16'h00ad);
		cnt(24);
		chk("softfuse", 0, n);
		wr(5'h0a, 16'h0002);
		cnt(20);
		chk("retry", 16, n);
		wr(5'h0a, 16'h0008);
		cy(16);
		rd(5'h0a, 16'h0000);
		// Expected sum left at zero, so the computed sum cannot match
		chk("selftest", 1'b1, selftestFail);
	endtask
	// ==========
	// Main sequence
	initial begin
		{sys_rst, regWrite, regRead, polarityPin, convSeqDone} = 5'h10;
		{regAddr, regWrData, firstInput, faults} = '0;
		{n_mismatch, checks_done, cyc} = '0;
		cy(3);
		chk("reset", 4'h4, outCtl);
		@(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_pol();
		t_act();
		t_conv();
		t_lim();
		t_fuse();
		wrap_up();
	end
endmodule

// ### tb/trigger_fault_regs_monitor.sv
// Port checks for the trigger and fault register block.
// Assumes one clk domain and the async active-high sys_rst.
`timescale 1ns/1ps
module trigger_fault_regs_monitor #(
	parameter int CRC_WORDS = 8,
	parameter int RUN_MAX = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	// Engines
	input wire logic convSeqDone,
	input wire logic convRun,
	input wire logic convAbort,
	input wire logic fuseLatchWe,
	input wire logic [3:0] fuseAddr,
	input wire logic secondChanLive
);
	// ==========
	// Helpers
	logic singleRun_r;
	logic trigWr;
	assign trigWr = regWrite && regAddr == 5'h0a;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Mode copy; soft reset not tracked, bench never mixes the two
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) singleRun_r <= 1'b0;
		else if (regWrite && regAddr == 5'h08) singleRun_r <= regWrData[0];
	end
	// ==========
	// Assertions
	conv_start_a: assert property (trigWr && regWrData[0] |=> convRun)
		else $error("conversion did not start");
	conv_stop_a: assert property (trigWr && !regWrData[0] |=> !convRun)
		else $error("conversion did not stop");
	conv_hold_a: assert property (!singleRun_r && convRun && !regWrite |=> convRun)
		else $error("continuous run dropped by itself");
	run_done_a: assert property (singleRun_r && convSeqDone && !regWrite |=> !convRun)
		else $error("single run not cleared at done");
	abort_pulse_a: assert property (singleRun_r && convRun && trigWr && !regWrData[0]
		|=> convAbort ##1 !convAbort)
		else $error("abort pulse wrong");
	// Latch enable is one flop behind the go bit, so it rises two edges after the write
	fuse_go_a: assert property (trigWr && regWrData[1] && !fuseLatchWe |=> ##1 fuseLatchWe)
		else $error("fuse reload did not start");
	fuse_walk_a: assert property (fuseLatchWe && fuseAddr != 4'hf
		|=> fuseLatchWe && fuseAddr == $past(fuseAddr) + 4'h1)
		else $error("fuse walk broken");
	chan_live_a: assert property (regWrite && regAddr == 5'h0b
		|=> ##1 secondChanLive == $past(regWrData[0], 2))
		else $error("channel live flag wrong");
	cover property (singleRun_r && convSeqDone);
	cover property (convAbort);
	cover property ($rose(fuseLatchWe));
endmodule

bind trigger_fault_regs trigger_fault_regs_monitor #(.CRC_WORDS(CRC_WORDS), .RUN_MAX(RUN_MAX))
	trigger_fault_regs_monitor_i (.clk, .sys_rst, .regAddr, .regWrData, .regWrite,
	.convSeqDone, .convRun, .convAbort, .fuseLatchWe, .fuseAddr, .secondChanLive);
